// >>> common/osc_trim_pkg.sv
// Package: register map, field layout, timing and types of the trim and clock switch block
package osc_trim_pkg;

  // Bus widths
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;

  // Word offsets; the byte address is four times the index
  localparam logic [15:0] IDX_FACTORY_TRIM_HIGH = 16'hdee0;
  localparam logic [15:0] IDX_FACTORY_TRIM_LOW = 16'hdee1;
  localparam logic [15:0] IDX_OSC_TRIM_HIGH = 16'h0000;
  localparam logic [15:0] IDX_OSC_TRIM_LOW = 16'h0001;
  localparam logic [15:0] IDX_CLOCK_CTRL_STATUS = 16'h0002;
  localparam logic [15:0] IDX_TRIM_PROG_CTRL = 16'h0003;
  localparam logic [15:0] IDX_USER_TRIM_HIGH = 16'h0004;
  localparam logic [15:0] IDX_USER_TRIM_LOW = 16'h0005;

  // Field positions
  localparam int TRIM_LOW_LSB = 5;
  localparam int TRIM_LOW_MSB = 6;
  localparam int CCS_SLOW_SELECT = 0;
  localparam int CCS_FAST_FLAG = 1;
  localparam int CCS_SLOW_FLAG = 2;
  localparam int PROG_GO_BIT = 0;
  localparam int PROG_LATCH_BIT = 1;

  // Reset and erase values
  localparam logic [7:0] TRIM_HIGH_RESET = 8'hff;
  localparam logic [1:0] TRIM_LOW_RESET = 2'h3;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // Factory trim bytes; arbitrary neutral values
  localparam logic [7:0] FACTORY_HIGH_DEFAULT = 8'h80;
  localparam logic [7:0] FACTORY_LOW_DEFAULT = 8'h40;

  // Startup clock option codes
  localparam logic [1:0] STARTUP_FAST = 2'h0;
  localparam logic [1:0] STARTUP_SLOW = 2'h1;
  localparam logic [1:0] STARTUP_EXT = 2'h2;

  // Switch sequence counts
  localparam logic [3:0] SLOW_WAIT_EDGES = 4'h3;
  localparam logic [3:0] FAST_WAIT_EDGES = 4'h8;
  localparam logic [3:0] FAST_FLAG_EDGES = 4'h2;

  // Nonvolatile programming time
  localparam int CLK_PERIOD_NS = 5;
  localparam int PROG_TIME_NS = 5000000;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int PROG_CNT_W = 21;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Pins sampled from outside the clock domain
  typedef struct packed {
    logic fast_osc_clk;
    logic slow_osc_clk;
    logic incircuit_comm;
    logic auto_wakeup;
    logic readout_protect;
    logic [1:0] startup_clock_option;
  } osc_pins_type;

  localparam int PINS_W = $bits(osc_pins_type);

  // Oscillator control outputs
  typedef struct packed {
    logic fast_osc_enable;
    logic slow_osc_enable;
    logic sys_clock_slow;
    logic clock_hold_high;
  } osc_ctrl_type;

  typedef enum logic [2:0] {
    ST_FAST_RUN,
    ST_TO_SLOW_WAIT,
    ST_TO_SLOW_EDGE,
    ST_SLOW_RUN,
    ST_TO_FAST_COUNT,
    ST_TO_FAST_CLEAR,
    ST_TO_FAST_FLAG,
    ST_TO_FAST_EDGE
  } switch_state_type;

endpackage : osc_trim_pkg

// >>> src/osc_trim_clock_switch.sv
// Fast RC trim, user trim programming and glitch-free clock switch with AXI4-Lite registers
`timescale 1ns/100ps

module osc_trim_clock_switch
  import osc_trim_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // Oscillator pins and options
  input wire osc_pins_type pins,
  // Oscillator control and trim
  output osc_ctrl_type osc_ctrl,
  output logic [9:0] fast_osc_trim,
  output logic prog_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [PINS_W-1:0] sync1_q, sync2_q, sync3_q;
  osc_pins_type pin_s, pin_prev;

  // Two flops per pin, a third for edges; no reset, so the startup option
  // has settled by the time reset lifts and no false edge follows it
  genvar gi;
  generate
    for (gi = 0; gi < PINS_W; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        sync1_q[gi] <= pins[gi];
        sync2_q[gi] <= sync1_q[gi];
        sync3_q[gi] <= sync2_q[gi];
      end
    end
  endgenerate

  assign pin_s = osc_pins_type'(sync2_q);
  assign pin_prev = osc_pins_type'(sync3_q);

  logic fast_rise, slow_rise, protect_fall;
  assign fast_rise = pin_s.fast_osc_clk & ~pin_prev.fast_osc_clk;
  assign slow_rise = pin_s.slow_osc_clk & ~pin_prev.slow_osc_clk;
  assign protect_fall = ~pin_s.readout_protect & pin_prev.readout_protect;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite channel capture

  logic aw_held_q, w_held_q, wlane_q, bvalid_q, rvalid_q, do_write;
  logic [15:0] aw_idx_q, ar_idx;
  logic [7:0] wbyte_q;
  logic [1:0] bresp_q, rresp_q;
  logic [DATA_W-1:0] rdata_q;

  assign awready = ~aw_held_q & ~bvalid_q;
  assign wready = ~w_held_q & ~bvalid_q;
  assign arready = ~rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  // Write goes once both halves are held and no response is pending
  assign do_write = aw_held_q & w_held_q & ~bvalid_q;
  assign ar_idx = araddr[ADDR_W-1:2];

  // Address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_idx_q <= 16'h0000;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held_q <= 1'b1;
        aw_idx_q <= awaddr[ADDR_W-1:2];
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_q <= 1'b1;
        wbyte_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trim register and programming control

  logic [7:0] trim_high_q, latch_high_q, latch_low_q, nv_high_q, nv_low_q;
  logic [1:0] trim_low_q;
  logic latch_en_q, prog_go_q, wr_en, prog_done, user_wr_ok;
  logic [PROG_CNT_W-1:0] prog_cnt_q;

  assign wr_en = do_write & wlane_q;
  assign prog_done = prog_go_q && (prog_cnt_q == PROG_CNT_W'(PROG_CYCLES_P - 1));
  // Latching only in write mode, not while programming, not under protection
  assign user_wr_ok = wr_en & latch_en_q & ~prog_go_q & ~pin_s.readout_protect;

  // Trim register; all ones after every reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trim_high_q <= TRIM_HIGH_RESET;
      trim_low_q <= TRIM_LOW_RESET;
    end else if (wr_en && aw_idx_q == IDX_OSC_TRIM_HIGH) begin
      trim_high_q <= wbyte_q;
    end else if (wr_en && aw_idx_q == IDX_OSC_TRIM_LOW) begin
      trim_low_q <= wbyte_q[TRIM_LOW_MSB:TRIM_LOW_LSB];
    end
  end

  assign fast_osc_trim = {trim_high_q, trim_low_q};

  // Latch and program bits; a reset simply drops the cycle in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_en_q <= 1'b0;
      prog_go_q <= 1'b0;
      prog_cnt_q <= '0;
    end else if (prog_go_q) begin
      prog_cnt_q <= prog_cnt_q + PROG_CNT_W'(1);
      if (prog_done) begin
        prog_go_q <= 1'b0;
        latch_en_q <= 1'b0;
      end
    end else if (wr_en && aw_idx_q == IDX_TRIM_PROG_CTRL) begin
      latch_en_q <= wbyte_q[PROG_LATCH_BIT];
      // Program only starts from write mode and with protection off
      if (latch_en_q && wbyte_q[PROG_GO_BIT] && !pin_s.readout_protect) begin
        prog_go_q <= 1'b1;
        prog_cnt_q <= '0;
      end
    end
  end

  assign prog_busy = prog_go_q;

  // Latches capture user trim writes only in write mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_high_q <= ERASED_BYTE;
      latch_low_q <= ERASED_BYTE;
    end else if (user_wr_ok && aw_idx_q == IDX_USER_TRIM_HIGH) begin
      latch_high_q <= wbyte_q;
    end else if (user_wr_ok && aw_idx_q == IDX_USER_TRIM_LOW) begin
      latch_low_q <= wbyte_q;
    end
  end

  // Nonvolatile cells keep their content across reset, hence no reset term
  always_ff @(posedge aclk) begin
    if (protect_fall) begin
      nv_high_q <= ERASED_BYTE;
      nv_low_q <= ERASED_BYTE;
    end else if (prog_done) begin
      nv_high_q <= latch_high_q;
      nv_low_q <= latch_low_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock switch sequencer

  switch_state_type state_q;
  logic slow_select_q;
  logic fast_flag_q;
  logic slow_flag_q;
  logic [3:0] edge_cnt_q;
  logic start_done_q;
  logic want_slow;

  // In-circuit mode overrides the select bit
  assign want_slow = slow_select_q & ~pin_s.incircuit_comm;

  // Select bit from software, plus startup option once after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slow_select_q <= 1'b0;
      start_done_q <= 1'b0;
    end else if (!start_done_q) begin
      start_done_q <= 1'b1;
      slow_select_q <= (pin_s.startup_clock_option == STARTUP_SLOW);
    end else if (wr_en && aw_idx_q == IDX_CLOCK_CTRL_STATUS) begin
      slow_select_q <= wbyte_q[CCS_SLOW_SELECT];
    end
  end

  // Select changes are only looked at in the two run states
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_FAST_RUN;
      fast_flag_q <= 1'b1;
      slow_flag_q <= 1'b0;
      edge_cnt_q <= 4'h0;
    end else begin
      case (state_q)
        ST_FAST_RUN: begin
          if (want_slow && start_done_q) begin
            state_q <= ST_TO_SLOW_WAIT;
            fast_flag_q <= 1'b0;
            edge_cnt_q <= 4'h0;
          end
        end
        ST_TO_SLOW_WAIT: begin
          if (slow_rise) begin
            edge_cnt_q <= edge_cnt_q + 4'h1;
            if (edge_cnt_q == SLOW_WAIT_EDGES - 4'h1) begin
              slow_flag_q <= 1'b1;
              state_q <= ST_TO_SLOW_EDGE;
            end
          end
        end
        ST_TO_SLOW_EDGE: begin
          if (slow_rise) begin
            state_q <= ST_SLOW_RUN;
          end
        end
        ST_SLOW_RUN: begin
          if (!want_slow) begin
            state_q <= ST_TO_FAST_COUNT;
            edge_cnt_q <= 4'h0;
          end
        end
        ST_TO_FAST_COUNT: begin
          if (fast_rise) begin
            edge_cnt_q <= edge_cnt_q + 4'h1;
            if (edge_cnt_q == FAST_WAIT_EDGES - 4'h1) begin
              state_q <= ST_TO_FAST_CLEAR;
            end
          end
        end
        ST_TO_FAST_CLEAR: begin
          if (slow_rise) begin
            slow_flag_q <= 1'b0;
            edge_cnt_q <= 4'h0;
            state_q <= ST_TO_FAST_FLAG;
          end
        end
        ST_TO_FAST_FLAG: begin
          if (fast_rise) begin
            edge_cnt_q <= edge_cnt_q + 4'h1;
            if (edge_cnt_q == FAST_FLAG_EDGES - 4'h1) begin
              fast_flag_q <= 1'b1;
              state_q <= ST_TO_FAST_EDGE;
            end
          end
        end
        ST_TO_FAST_EDGE: begin
          if (fast_rise) begin
            state_q <= ST_FAST_RUN;
          end
        end
        default: begin
          state_q <= ST_FAST_RUN;
        end
      endcase
    end
  end

  // Oscillator enables and clock mux select, registered to avoid glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_ctrl <= '{fast_osc_enable: 1'b1, slow_osc_enable: 1'b0,
                    sys_clock_slow: 1'b0, clock_hold_high: 1'b0};
    end else begin
      // Fast RC runs except when the slow clock alone is in use
      osc_ctrl.fast_osc_enable <= (state_q != ST_SLOW_RUN)
                                  | pin_s.incircuit_comm;
      // Slow RC off only in steady fast run without wake-up halt or external
      osc_ctrl.slow_osc_enable <= (state_q != ST_FAST_RUN) | pin_s.auto_wakeup
        | (pin_s.startup_clock_option == STARTUP_EXT);
      osc_ctrl.sys_clock_slow <= (state_q == ST_SLOW_RUN)
        | (state_q == ST_TO_FAST_COUNT) | (state_q == ST_TO_FAST_CLEAR)
        | (state_q == ST_TO_FAST_FLAG) | (state_q == ST_TO_FAST_EDGE);
      // Output held high between leaving fast and taking the slow edge
      osc_ctrl.clock_hold_high <= (state_q == ST_TO_SLOW_WAIT)
                                  | (state_q == ST_TO_SLOW_EDGE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write response and read data

  logic known_w;
  assign known_w = (aw_idx_q == IDX_OSC_TRIM_HIGH) | (aw_idx_q == IDX_OSC_TRIM_LOW)
    | (aw_idx_q == IDX_CLOCK_CTRL_STATUS) | (aw_idx_q == IDX_TRIM_PROG_CTRL)
    | (aw_idx_q == IDX_USER_TRIM_HIGH) | (aw_idx_q == IDX_USER_TRIM_LOW);

  // Ignored user trim writes still answer okay, as the bus cannot tell
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= known_w ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Reads answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      case (ar_idx)
        IDX_OSC_TRIM_HIGH: rdata_q[7:0] <= trim_high_q;
        IDX_OSC_TRIM_LOW: rdata_q[TRIM_LOW_MSB:TRIM_LOW_LSB] <= trim_low_q;
        IDX_FACTORY_TRIM_HIGH: rdata_q[7:0] <= FACTORY_HIGH_DEFAULT;
        IDX_FACTORY_TRIM_LOW: rdata_q[7:0] <= FACTORY_LOW_DEFAULT;
        IDX_CLOCK_CTRL_STATUS: begin
          rdata_q[CCS_SLOW_SELECT] <= slow_select_q;
          rdata_q[CCS_FAST_FLAG] <= fast_flag_q;
          rdata_q[CCS_SLOW_FLAG] <= slow_flag_q;
        end
        IDX_TRIM_PROG_CTRL: begin
          rdata_q[PROG_GO_BIT] <= prog_go_q;
          rdata_q[PROG_LATCH_BIT] <= latch_en_q;
        end
        IDX_USER_TRIM_HIGH, IDX_USER_TRIM_LOW: begin
          // No data while latching or protected
          if (latch_en_q || pin_s.readout_protect) begin
            rresp_q <= RESP_SLVERR;
          end else begin
            rdata_q[7:0] <= (ar_idx == IDX_USER_TRIM_HIGH) ? nv_high_q : nv_low_q;
          end
        end
        default: rresp_q <= RESP_SLVERR;
      endcase
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : osc_trim_clock_switch

// >>> tb/osc_trim_monitor.sv
// Checker for bus answers, trim reset and oscillator handover
`timescale 1ns/100ps
module osc_trim_monitor
  import osc_trim_pkg::*;
#(
  parameter int PROG_CYCLES_P = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [DATA_W-1:0] rdata,
  // Oscillator side
  input wire osc_pins_type pins,
  input wire osc_ctrl_type osc_ctrl,
  input wire logic [9:0] fast_osc_trim,
  input wire logic prog_busy
);
  ////////////////////////////////////////////////////////////
  // One domain, so one clock and one reset serve all
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Trim is all ones the moment reset lifts
  property p_trim_reset;
    $rose(aresetn) |-> fast_osc_trim == 10'h3ff;
  endproperty
  a_trim_reset: assert property (p_trim_reset)
    else $error("trim not all ones after reset");

  // Programming cycle lasts at least eight cycles
  property p_prog_hold;
    $rose(prog_busy) |-> prog_busy [*8];
  endproperty
  a_prog_hold: assert property (p_prog_hold)
    else $error("programming cycle ended early");

  // Fast RC is off the moment slow takes over; a quick return may restart it
  property p_fast_stop;
    $rose(osc_ctrl.sys_clock_slow) |-> !osc_ctrl.fast_osc_enable;
  endproperty
  a_fast_stop: assert property (p_fast_stop)
    else $error("fast oscillator still on after switch");

  // Slow RC stops after return, unless something keeps it on
  property p_slow_stop;
    $fell(osc_ctrl.sys_clock_slow) && pins.startup_clock_option != STARTUP_EXT
      && !pins.auto_wakeup && !pins.incircuit_comm |-> ##[0:3] !osc_ctrl.slow_osc_enable;
  endproperty
  a_slow_stop: assert property (p_slow_stop)
    else $error("slow oscillator still on after return");

  // Write channels refused while a response waits
  property p_w_block;
    bvalid |-> !awready && !wready;
  endproperty
  a_w_block: assert property (p_w_block)
    else $error("write accepted while response pending");

  // Read address refused while read data waits
  property p_ar_block;
    rvalid |-> !arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read accepted while data pending");

  // Read data one edge after the address is taken
  property p_r_lat;
    arvalid && arready |=> rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read data late");

  // Response drops once taken
  property p_b_clear;
    bvalid && bready |=> !bvalid;
  endproperty
  a_b_clear: assert property (p_b_clear)
    else $error("write response repeated");

  // Registers are bytes, upper data bits stay zero
  property p_r_zero;
    rvalid |-> rdata[31:8] == 24'h0;
  endproperty
  a_r_zero: assert property (p_r_zero)
    else $error("upper read data bits set");

  // Main scenarios
  c_to_slow: cover property ($rose(osc_ctrl.sys_clock_slow));
  c_to_fast: cover property ($fell(osc_ctrl.sys_clock_slow));
  c_prog: cover property ($fell(prog_busy));
endmodule : osc_trim_monitor

// >>> tb/rc_osc_trim_and_clock_switch_bench.sv
// Register level bench for trim, user trim programming and clock switch
`timescale 1ns/100ps
module rc_osc_trim_and_clock_switch_bench
  import osc_trim_pkg::*;
;
  localparam int PROG_CYCLES_P = 16;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, prog_busy;
  logic [ADDR_W-1:0] awaddr = 18'h0, araddr = 18'h0;
  logic [DATA_W-1:0] wdata = 32'h0, rdata, q;
  logic [1:0] bresp, rresp, r;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [3:0] wstrb = 4'h1, ph = 4'h0;
  osc_pins_type pins = 7'h0;
  osc_ctrl_type osc_ctrl;
  logic [9:0] fast_osc_trim;
  int errors = 0, comparisons = 0;
  ////////////////////////////////////////////////////////////
  always #2.5 aclk = ~aclk;

  // Oscillator pins: fast every 4 cycles, slow every 16, both slow enough to sample
  always @(posedge aclk) begin
    ph <= ph + 4'h1;
    pins.fast_osc_clk <= ph[1];
    pins.slow_osc_clk <= ph[3];
  end

  osc_trim_clock_switch #(.PROG_CYCLES_P(PROG_CYCLES_P)) osc_trim_clock_switch_i (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid,
    .rready, .rdata, .rresp, .pins, .osc_ctrl, .fast_osc_trim, .prog_busy
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %s: saw %h want %h", $time, m, seen, exp);
    end
  endtask : check

  task automatic close_out;
    if (errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // One bus access; handshakes judged at the negedge before the taking edge
  task automatic acc(input bit w, input logic [15:0] i, input logic [7:0] d,
                     output logic [31:0] qo, output logic [1:0] ro);
    bit ha, hw, hr, done;
    done = 1'b0;
    qo = 32'h0;
    @(posedge aclk);
    awvalid <= w;
    wvalid <= w;
    arvalid <= !w;
    awaddr <= {i, 2'h0};
    araddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    bready <= w;
    rready <= !w;
    while (!done) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hr = arvalid && arready;
      if (bvalid && bready) begin
        ro = bresp;
        done = 1'b1;
      end
      if (rvalid && rready) begin
        qo = rdata;
        ro = rresp;
        done = 1'b1;
      end
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hr) arvalid <= 1'b0;
      if (done) bready <= 1'b0;
      if (done) rready <= 1'b0;
    end
    @(negedge aclk);
  endtask : acc

  task automatic wr(input logic [15:0] i, input logic [7:0] d, input logic [1:0] er);
    acc(1'b1, i, d, q, r);
    check(32'(r), 32'(er), "bresp");
  endtask : wr

  task automatic rd(input logic [15:0] i, input logic [31:0] e, input logic [1:0] er);
    acc(1'b0, i, 8'h0, q, r);
    check(q, e, "rdata");
    check(32'(r), 32'(er), "rresp");
  endtask : rd

  // Software side of the switch: poll status until the flag shows
  task automatic poll(input logic [7:0] m);
    repeat (100) begin
      acc(1'b0, IDX_CLOCK_CTRL_STATUS, 8'h0, q, r);
      if ((q[7:0] & m) === m) break;
    end
    check(32'(q[7:0] & m), 32'(m), "flag");
  endtask : poll

  task automatic rst(input logic [1:0] opt);
    @(posedge aclk);
    aresetn <= 1'b0;
    pins.startup_clock_option <= opt;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst

  // Watchdog; the tests need well under 1000 of its 20000 cycles
  initial begin
    #100000;
    errors++;
    close_out();
  end

  // Main sequence
  initial begin
    rst(STARTUP_FAST);
    rd(IDX_OSC_TRIM_HIGH, 32'hff, RESP_OKAY);
    rd(IDX_OSC_TRIM_LOW, 32'h60, RESP_OKAY);
    rd(IDX_FACTORY_TRIM_HIGH, {24'h0, FACTORY_HIGH_DEFAULT}, RESP_OKAY);
    rd(IDX_FACTORY_TRIM_LOW, {24'h0, FACTORY_LOW_DEFAULT}, RESP_OKAY);
    rd(16'h0006, 32'h0, RESP_SLVERR);
    wr(16'h0006, 8'h55, RESP_SLVERR);
    // Trim assembly, then a mid-run reset restores it
    wr(IDX_OSC_TRIM_HIGH, 8'ha5, RESP_OKAY);
    wr(IDX_OSC_TRIM_LOW, 8'hdf, RESP_OKAY);
    check(32'(fast_osc_trim), 32'h296, "trim");
    rd(IDX_OSC_TRIM_LOW, 32'h40, RESP_OKAY);
    rst(STARTUP_FAST);
    check(32'(fast_osc_trim), 32'h3ff, "trim reset");
    // Latch, program, and the refusals around it
    wr(IDX_TRIM_PROG_CTRL, 8'h02, RESP_OKAY);
    wr(IDX_USER_TRIM_HIGH, 8'h3c, RESP_OKAY);
    wr(IDX_USER_TRIM_LOW, 8'h20, RESP_OKAY);
    rd(IDX_USER_TRIM_HIGH, 32'h0, RESP_SLVERR);
    wr(IDX_TRIM_PROG_CTRL, 8'h03, RESP_OKAY);
    rd(IDX_TRIM_PROG_CTRL, 32'h03, RESP_OKAY);
    check(32'(prog_busy), 32'h1, "busy");
    repeat (100) if (prog_busy) @(negedge aclk);
    rd(IDX_TRIM_PROG_CTRL, 32'h0, RESP_OKAY);
    rd(IDX_USER_TRIM_HIGH, 32'h3c, RESP_OKAY);
    rd(IDX_USER_TRIM_LOW, 32'h20, RESP_OKAY);
    wr(IDX_USER_TRIM_HIGH, 8'h99, RESP_OKAY);
    rd(IDX_USER_TRIM_HIGH, 32'h3c, RESP_OKAY);
    // Reset in mid-programming aborts the cycle
    wr(IDX_TRIM_PROG_CTRL, 8'h02, RESP_OKAY);
    wr(IDX_TRIM_PROG_CTRL, 8'h03, RESP_OKAY);
    rst(STARTUP_FAST);
    check(32'(prog_busy), 32'h0, "abort");
    rd(IDX_TRIM_PROG_CTRL, 32'h0, RESP_OKAY);
    // Protection blocks reads; removing it erases both bytes
    @(posedge aclk);
    pins.readout_protect <= 1'b1;
    repeat (4) @(negedge aclk);
    rd(IDX_USER_TRIM_HIGH, 32'h0, RESP_SLVERR);
    @(posedge aclk);
    pins.readout_protect <= 1'b0;
    repeat (4) @(negedge aclk);
    rd(IDX_USER_TRIM_HIGH, 32'hff, RESP_OKAY);
    rd(IDX_USER_TRIM_LOW, 32'hff, RESP_OKAY);
    // Switch to the slow oscillator
    wr(IDX_CLOCK_CTRL_STATUS, 8'h01, RESP_OKAY);
    rd(IDX_CLOCK_CTRL_STATUS, 32'h01, RESP_OKAY);
    check(32'(osc_ctrl.clock_hold_high), 32'h1, "hold");
    check(32'(osc_ctrl.slow_osc_enable), 32'h1, "slow on");
    poll(8'h04);
    repeat (100) if (!osc_ctrl.sys_clock_slow) @(negedge aclk);
    check(32'(osc_ctrl.sys_clock_slow), 32'h1, "on slow");
    repeat (2) @(negedge aclk);
    check(32'(osc_ctrl.fast_osc_enable), 32'h0, "fast off");
    // And back to the fast oscillator
    wr(IDX_CLOCK_CTRL_STATUS, 8'h00, RESP_OKAY);
    repeat (2) @(negedge aclk); // Enable follows the state by one edge
    check(32'(osc_ctrl.fast_osc_enable), 32'h1, "fast on");
    rd(IDX_CLOCK_CTRL_STATUS, 32'h04, RESP_OKAY);
    poll(8'h02);
    repeat (100) if (osc_ctrl.sys_clock_slow) @(negedge aclk);
    check(32'(osc_ctrl.sys_clock_slow), 32'h0, "on fast");
    rd(IDX_CLOCK_CTRL_STATUS, 32'h02, RESP_OKAY);
    repeat (4) @(negedge aclk);
    check(32'(osc_ctrl.slow_osc_enable), 32'h0, "slow off");
    // A select change in mid-switch waits for the switch to end
    wr(IDX_CLOCK_CTRL_STATUS, 8'h01, RESP_OKAY);
    wr(IDX_CLOCK_CTRL_STATUS, 8'h00, RESP_OKAY);
    repeat (300) if (!osc_ctrl.sys_clock_slow) @(negedge aclk);
    check(32'(osc_ctrl.sys_clock_slow), 32'h1, "switch completes");
    repeat (300) if (osc_ctrl.sys_clock_slow) @(negedge aclk);
    check(32'(osc_ctrl.sys_clock_slow), 32'h0, "then returns");
    // Slow startup, then in-circuit mode forces fast
    rst(STARTUP_SLOW);
    repeat (300) if (!osc_ctrl.sys_clock_slow) @(negedge aclk);
    check(32'(osc_ctrl.sys_clock_slow), 32'h1, "slow startup");
    @(posedge aclk);
    pins.incircuit_comm <= 1'b1;
    repeat (300) if (osc_ctrl.sys_clock_slow) @(negedge aclk);
    check(32'(osc_ctrl.sys_clock_slow), 32'h0, "forced fast");
    @(posedge aclk);
    pins.incircuit_comm <= 1'b0;
    // Slow RC kept on for external clock and for wake-up halt
    rst(STARTUP_EXT);
    repeat (4) @(negedge aclk);
    check(32'(osc_ctrl.slow_osc_enable), 32'h1, "ext keeps slow");
    rst(STARTUP_FAST);
    pins.auto_wakeup <= 1'b1;
    repeat (4) @(negedge aclk);
    check(32'(osc_ctrl.slow_osc_enable), 32'h1, "halt wakes slow");
    close_out();
  end
endmodule : rc_osc_trim_and_clock_switch_bench

bind osc_trim_clock_switch osc_trim_monitor #(.PROG_CYCLES_P(PROG_CYCLES_P)) osc_trim_monitor_i (
  .aclk, .aresetn, .awready, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid,
  .rdata, .pins, .osc_ctrl, .fast_osc_trim, .prog_busy
);
